// ===== design/rtc_pkg.sv
// Shared constants and types for the two-wire slave port of the clock and RAM device.
// Assumes a 10 MHz system clock and a flat 32K byte map behind a 15-bit pointer.
package rtc_pkg;

  // Bus identity and map layout
  localparam logic [7:0]  SLAVE_ADDR          = 8'hD0;
  localparam int          PTR_W               = 15;
  localparam logic [14:0] RAM_LAST            = 15'h7FEF;
  localparam logic [14:0] RSV_FIRST           = 15'h7FF0;
  localparam logic [14:0] RSV_LAST            = 15'h7FF6;
  localparam int          RAM_BYTES           = 32752;
  localparam logic [14:0] PTR_RESET           = 15'h0000;

  // Timekeeping register offsets
  localparam logic [14:0] SUBSECOND_COUNT     = 15'h7FF7;
  localparam logic [14:0] CLOCK_CONTROL       = 15'h7FF8;
  localparam logic [14:0] SECONDS_COUNT       = 15'h7FF9;
  localparam logic [14:0] MINUTES_COUNT       = 15'h7FFA;
  localparam logic [14:0] HOURS_COUNT         = 15'h7FFB;
  localparam logic [14:0] TAMPER_AND_WEEKDAY  = 15'h7FFC;
  localparam logic [14:0] DAY_OF_MONTH        = 15'h7FFD;
  localparam logic [14:0] MONTH_COUNT         = 15'h7FFE;
  localparam logic [14:0] YEAR_COUNT          = 15'h7FFF;
  localparam int          TK_COUNT            = 9;
  localparam logic [3:0]  TK_CTRL_IDX         = 4'h1;
  localparam logic [7:0]  TK_RESET            = 8'h00;

  // Byte framing
  localparam logic [3:0]  BIT_ACK             = 4'h8;
  localparam logic [3:0]  BIT_DONE            = 4'h9;

  // Timing
  localparam int          SYS_CLK_HZ          = 10_000_000;
  localparam int          BUS_IDLE_GAP_NS     = 1300;
  localparam int          POWER_UP_DESELECT_MIN_MS = 40;
  localparam int          POWER_UP_DESELECT_MAX_MS = 200;
  localparam int          DESELECT_CYCLES_DEF =
    POWER_UP_DESELECT_MIN_MS * (SYS_CLK_HZ / 1000);

  // Transfer phases
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_DEV  = 7'h02,
    ST_PHI  = 7'h04,
    ST_PLO  = 7'h08,
    ST_WR   = 7'h10,
    ST_RD   = 7'h20,
    ST_SKIP = 7'h40
  } rtc_state_e;

endpackage

// ===== design/rtc_sync2.sv
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes the caller reads only q; the first stage feeds the second alone.
`timescale 1ns/1ns
module rtc_sync2 #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= RESET_VAL;
      q      <= RESET_VAL;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule

// ===== design/rtc_serial_port.sv
// Two-wire slave port with the 32K byte RAM and timekeeping register map behind it.
// Assumes SCL, SDA and the power-fail level arrive unsynchronised; SDA is open drain.
//
// Functional notes
// - Respond only to slave address D0h.
// - RAM at 0-7FEF, 7FF0-7FF6 reserved.
// - Timekeeping registers occupy 7FF7h through 7FFFh.
// - Power fail aborts access, clears pointer.
// - Ignore bus inputs while power failed.
// - Keep write protection for deselect interval.
// - START is SDA fall with SCL high.
// - STOP is SDA rise with SCL high.
// - SDA changes only while SCL low.
// - Eight-bit bytes plus ninth acknowledge bit.
// - Acknowledge holds SDA low during high.
// - Release SDA when master withholds acknowledge.
// - Two address bytes load pointer, top ignored.
// - Read after repeated START sends pointed byte.
// - Advance pointer only on master acknowledge.
// - Keep sending while master acknowledges.
// - Pointer wraps from top to bottom.
// - Read without load starts at kept pointer.
// - Deselect interval at least 40 ms.
// - Store written byte, advance on acknowledge.
// - Acknowledge slave address and address bytes.
`timescale 1ns/1ns
module rtc_serial_port
  import rtc_pkg::*;
#(
  parameter int DESELECT_CYCLES = DESELECT_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Two-wire bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Supply monitor
  input  wire logic       power_fail,
  // Status and control
  output logic            write_protect,
  output logic [7:0]      clock_control
);

  localparam int CNT_W = $clog2(DESELECT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(DESELECT_CYCLES);

  // Reset release
  logic [1:0] rst_q;
  logic       rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_q[1];

  // Pin synchronisation
  logic scl_s;
  logic sda_s;
  logic pf_s;

  // Idle levels after reset: both lines high, supply good
  rtc_sync2 #(
    .WIDTH     (3),
    .RESET_VAL (3'h6)
  ) u_sync (
    .clk   (sys_clk),
    .rst_n (rst_sync_n),
    .d     ({scl_in, sda_in, power_fail}),
    .q     ({scl_s, sda_s, pf_s})
  );

  // Bus condition detection
  // Both samples need SCL high, so data moving under SCL low never counts
  logic scl_d;
  logic sda_d;
  wire  scl_rise = scl_s & ~scl_d;
  wire  scl_fall = ~scl_s & scl_d;
  wire  bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire  bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Power-up deselect
  // Reloads while the supply is low and counts down once it returns
  logic [CNT_W-1:0] desel_cnt;
  logic [CNT_W-1:0] next_desel_cnt;
  wire              desel_busy = (desel_cnt != '0);

  always_comb begin
    next_desel_cnt = desel_cnt;
    if (pf_s) begin
      next_desel_cnt = CNT_LOAD;
    end else if (desel_busy) begin
      next_desel_cnt = desel_cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      desel_cnt     <= '0;
      write_protect <= 1'b0;
    end else begin
      desel_cnt     <= next_desel_cnt;
      write_protect <= pf_s | desel_busy;
    end
  end

  // Transfer state
  rtc_state_e       state;
  rtc_state_e       next_state;
  logic [3:0]       bit_cnt;
  logic [3:0]       next_bit_cnt;
  logic [7:0]       shreg;
  logic [7:0]       next_shreg;
  logic [PTR_W-1:0] ptr;
  logic [PTR_W-1:0] next_ptr;
  logic             drive_pend;
  logic             next_drive_pend;
  logic             next_sda_oe;
  logic             mack;
  logic             next_mack;
  logic             wr_en;

  // Map decode
  logic [7:0]       ram [0:RAM_BYTES-1];
  logic [7:0]       tk  [0:TK_COUNT-1];
  wire              in_ram   = (ptr <= RAM_LAST);
  wire              in_rsv   = (ptr >= RSV_FIRST) && (ptr <= RSV_LAST);
  wire              in_tk    = (ptr >= SUBSECOND_COUNT);
  wire [3:0]        tk_idx   = 4'(ptr - SUBSECOND_COUNT);
  wire [7:0]        ram_byte = ram[ptr];
  wire [7:0]        tk_byte  = tk[tk_idx];
  // Reserved locations read as zero
  wire [7:0]        rd_byte  = in_ram ? ram_byte : (in_tk && !in_rsv) ? tk_byte : 8'h00;
  wire [PTR_W-1:0]  ptr_inc  = ptr + PTR_W'(1);
  wire              addr_ok  = (shreg[7:1] == SLAVE_ADDR[7:1]);
  wire              rx_state = (state == ST_DEV) || (state == ST_PHI) ||
                               (state == ST_PLO) || (state == ST_WR);
  wire              counting = rx_state || (state == ST_RD);
  wire              tx_bit   = rd_byte[~bit_cnt[2:0]];

  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shreg      = shreg;
    next_ptr        = ptr;
    next_drive_pend = 1'b0;
    next_sda_oe     = sda_oe;
    next_mack       = mack;
    wr_en           = 1'b0;
    if (pf_s) begin
      next_state   = ST_IDLE;
      next_bit_cnt = 4'h0;
      next_ptr     = PTR_RESET;
      next_sda_oe  = 1'b0;
    end else if (write_protect) begin
      // A START seen now is lost; the master must send a fresh one
      next_state   = ST_IDLE;
      next_bit_cnt = 4'h0;
      next_sda_oe  = 1'b0;
    end else if (bus_start) begin
      next_state   = ST_DEV;
      next_bit_cnt = 4'h0;
      next_sda_oe  = 1'b0;
    end else if (bus_stop) begin
      next_state   = ST_IDLE;
      next_bit_cnt = 4'h0;
      next_sda_oe  = 1'b0;
    end else begin
      // Data goes out one clock after the fall, once pointer and count settle
      if (drive_pend) begin
        next_sda_oe = ~tx_bit;
      end
      if (scl_rise && counting && (bit_cnt != BIT_DONE)) begin
        next_bit_cnt = bit_cnt + 4'h1;
        if (bit_cnt < BIT_ACK) begin
          next_shreg = {shreg[6:0], sda_s};
        end else begin
          next_mack = ~sda_s;
        end
      end
      if (scl_fall) begin
        if (rx_state && (bit_cnt == BIT_ACK)) begin
          if ((state == ST_DEV) && !addr_ok) begin
            next_state = ST_SKIP;
          end else begin
            next_sda_oe = 1'b1;
          end
          // High byte lands first; shreg[7] is the ignored top address bit
          if (state == ST_PHI) begin
            next_ptr = {shreg[6:0], ptr[7:0]};
          end
          if (state == ST_PLO) begin
            next_ptr = {ptr[14:8], shreg};
          end
          if (state == ST_WR) begin
            wr_en = 1'b1;
          end
        end else if (rx_state && (bit_cnt == BIT_DONE)) begin
          next_sda_oe  = 1'b0;
          next_bit_cnt = 4'h0;
          case (state)
            ST_DEV: begin
              if (shreg[0]) begin
                next_state      = ST_RD;
                next_drive_pend = 1'b1;
              end else begin
                next_state = ST_PHI;
              end
            end
            ST_PHI: next_state = ST_PLO;
            ST_PLO: next_state = ST_WR;
            ST_WR:  next_ptr   = ptr_inc;
            default: next_state = ST_SKIP;
          endcase
        end else if (state == ST_RD) begin
          if (bit_cnt < BIT_ACK) begin
            next_drive_pend = 1'b1;
          end else if (bit_cnt == BIT_ACK) begin
            next_sda_oe = 1'b0;
          end else if (mack) begin
            // Master acknowledged: move on and send the next location
            next_ptr        = ptr_inc;
            next_bit_cnt    = 4'h0;
            next_drive_pend = 1'b1;
          end else begin
            next_state  = ST_SKIP;
            next_sda_oe = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      ptr        <= PTR_RESET;
      drive_pend <= 1'b0;
      sda_oe     <= 1'b0;
      sda_out    <= 1'b0;
      mack       <= 1'b0;
    end else begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      shreg      <= next_shreg;
      ptr        <= next_ptr;
      drive_pend <= next_drive_pend;
      sda_oe     <= next_sda_oe;
      sda_out    <= 1'b0;
      mack       <= next_mack;
    end
  end

  // General RAM holds its contents across reset
  always_ff @(posedge sys_clk) begin
    if (wr_en && in_ram) begin
      ram[ptr] <= shreg;
    end
  end

  // Timekeeping registers; reserved locations drop writes
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < TK_COUNT; i++) begin
        tk[i] <= TK_RESET;
      end
    end else if (wr_en && in_tk) begin
      tk[tk_idx] <= shreg;
    end
  end

  // Control register copy, one clock behind the store
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clock_control <= TK_RESET;
    end else begin
      clock_control <= tk[TK_CTRL_IDX];
    end
  end

endmodule

// ===== dv/rtc_serial_port_assertions.sv
// Concurrent checks on the ports of the two-wire slave port.
// Assumes the bench raises power_fail with SCL low and drops it after a STOP, with SCL high.
`timescale 1ns/1ns
module rtc_serial_port_assertions
  import rtc_pkg::*;
#(
  parameter int DESELECT_CYCLES = DESELECT_CYCLES_DEF
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Bus and status
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       power_fail,
  input wire logic       write_protect,
  input wire logic [7:0] clock_control
);
  int wp_run;

  // Length of the protection tail after the supply comes back
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) wp_run <= 0;
    else if (write_protect && !power_fail) wp_run <= wp_run + 1;
    else wp_run <= 0;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_out_low: assert property (sda_out == 1'b0)
    else $error("data output not low");
  a_wp_on_fail: assert property (power_fail [*4] |-> write_protect)
    else $error("no protection during power fail");
  a_wp_cause: assert property ($rose(write_protect) |-> power_fail)
    else $error("protection without power fail");
  a_no_drive_prot: assert property (write_protect [*3] |-> !sda_oe)
    else $error("data driven while protected");
  a_deselect_held: assert property ($fell(power_fail) && write_protect |=> write_protect [*8])
    else $error("protection dropped early");
  a_deselect_bound: assert property (wp_run <= DESELECT_CYCLES + 4)
    else $error("protection held too long");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
    else $error("data changed while clock high");
  a_ack_stable: assert property ($rose(scl_in) && sda_oe |-> sda_oe [*4])
    else $error("low not held through clock high");
  a_ctrl_on_ack: assert property ($changed(clock_control) |-> sda_oe)
    else $error("control changed without acknowledge");
endmodule

bind rtc_serial_port rtc_serial_port_assertions #(
  .DESELECT_CYCLES(DESELECT_CYCLES)
) i_rtc_serial_port_assertions (
  .sys_clk      (sys_clk),
  .rst_n        (rst_n),
  .scl_in       (scl_in),
  .sda_in       (sda_in),
  .sda_out      (sda_out),
  .sda_oe       (sda_oe),
  .power_fail   (power_fail),
  .write_protect(write_protect),
  .clock_control(clock_control)
);

// ===== dv/rtc_master_model.sv
// Two-wire bus master model: drives SCL and pulls SDA low.
// Assumes a pull-up on SDA; one SCL period is 8 clocks of 100 ns.
`timescale 1ns/1ns
module rtc_master_model (
  // Clock
  input  wire logic clk,
  // Bus
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Data set mid-low, sampled at the end of the high phase
  task automatic put_bit(input logic b, output logic r);
    sda_low = !b;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    r   = sda;
    scl = 1'b0;
    wait_clk(2);
  endtask

  task automatic start_cond();
    sda_low = 1'b0;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    sda_low = 1'b1;
    wait_clk(4);
    scl = 1'b0;
    wait_clk(2);
  endtask

  task automatic stop_cond();
    sda_low = 1'b1;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    sda_low = 1'b0;
    wait_clk(14);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r);
    put_bit(1'b1, nak);
  endtask

  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, r);
      d[i] = r;
    end
    put_bit(last, r);
  endtask
endmodule

// ===== dv/tb.sv
// Self-checking bench for the two-wire slave port.
// Assumes the bus master model and a pull-up on the resolved SDA line.
`timescale 1ns/1ns
module tb
  import rtc_pkg::*;
;
  localparam int DESELECT = 50;
  logic       sys_clk;
  logic       rst_n;
  logic       power_fail;
  logic       scl;
  logic       m_low;
  logic       sda_out;
  logic       sda_oe;
  logic       write_protect;
  logic [7:0] clock_control;
  logic       nak;
  logic [7:0] rd;
  int         mismatches;
  int         total_checks;
  wire        sda_line = m_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);

  rtc_serial_port #(.DESELECT_CYCLES(DESELECT)) i_rtc_serial_port (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .power_fail(power_fail), .write_protect(write_protect),
    .clock_control(clock_control)
  );
  rtc_master_model i_rtc_master_model (.clk(sys_clk), .sda(sda_line), .scl(scl), .sda_low(m_low));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic [7:0] d, input logic [7:0] exp_nak);
    i_rtc_master_model.wr_byte(d, nak);
    check({7'h00, nak}, exp_nak);
  endtask

  task automatic rd_chk(input logic last, input logic [7:0] exp);
    i_rtc_master_model.rd_byte(last, rd);
    check(rd, exp);
  endtask

  task automatic set_ptr(input logic [7:0] hi, input logic [7:0] lo);
    i_rtc_master_model.start_cond();
    send(8'hD0, 8'h00);
    send(hi, 8'h00);
    send(lo, 8'h00);
  endtask

  task automatic rd_start();
    i_rtc_master_model.start_cond();
    send(8'hD1, 8'h00);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // About 3100 clocks of traffic expected; cut off well beyond
  initial begin
    #3_000_000;
    mismatches++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    power_fail = 1'b0;
    mismatches = 0;
    total_checks = 0;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    check(clock_control, TK_RESET);
    set_ptr(8'hFF, 8'hFE);
    send(8'hA5, 8'h00);
    send(8'h3C, 8'h00);
    send(8'h5A, 8'h00);
    i_rtc_master_model.stop_cond();
    $display("test wrap write done");
    set_ptr(8'h7F, 8'hFE);
    rd_start();
    rd_chk(1'b0, 8'hA5);
    rd_chk(1'b0, 8'h3C);
    rd_chk(1'b1, 8'h5A);
    i_rtc_master_model.stop_cond();
    rd_start();
    rd_chk(1'b1, 8'h5A);
    i_rtc_master_model.stop_cond();
    $display("test sequential read done");
    set_ptr(8'h7F, 8'hF2);
    send(8'h77, 8'h00);
    i_rtc_master_model.stop_cond();
    set_ptr(8'h7F, 8'hF2);
    rd_start();
    rd_chk(1'b1, 8'h00);
    i_rtc_master_model.stop_cond();
    set_ptr(8'h7F, 8'hF8);
    send(8'h69, 8'h00);
    i_rtc_master_model.stop_cond();
    check(clock_control, 8'h69);
    i_rtc_master_model.start_cond();
    send(8'hD2, 8'h01);
    send(8'h00, 8'h01);
    i_rtc_master_model.stop_cond();
    $display("test map and address done");
    set_ptr(8'h00, 8'h10);
    power_fail = 1'b1;
    repeat (8) @(negedge sys_clk);
    check({7'h00, write_protect}, 8'h01);
    i_rtc_master_model.stop_cond();
    i_rtc_master_model.start_cond();
    send(8'hD0, 8'h01);
    i_rtc_master_model.stop_cond();
    power_fail = 1'b0;
    repeat (4) @(negedge sys_clk);
    i_rtc_master_model.start_cond();
    send(8'hD0, 8'h01);
    i_rtc_master_model.stop_cond();
    repeat (DESELECT) @(negedge sys_clk);
    check({7'h00, write_protect}, 8'h00);
    rd_start();
    rd_chk(1'b1, 8'h5A);
    i_rtc_master_model.stop_cond();
    $display("test power fail done");
    print_verdict();
  end
endmodule
